/* File: shared/fwb_pkg.sv */
// constants and types shared by both ends of the write-buffer command link
package fwb_pkg;

  // ---------------------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------------------
  localparam int FWB_ADDR_W = 24;
  localparam int FWB_DATA_W = 16;
  localparam int FWB_BLOCK_LSB = 16;           // 64 k-word blocks
  localparam int FWB_CNT_W = 5;                // only five count bits are kept
  localparam int FWB_BUF_DEPTH = 32;
  localparam logic [15:0] FWB_ID_CODE = 16'h5a5a;  // arbitrary identity value

  // ---------------------------------------------------------------------------
  // command codes (low byte of a write cycle)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FWB_C_RD_STATUS = 8'h70;
  localparam logic [7:0] FWB_C_CLEAR = 8'h50;
  localparam logic [7:0] FWB_C_RD_CONFIG = 8'h90;
  localparam logic [7:0] FWB_C_STS = 8'hb8;
  localparam logic [7:0] FWB_C_QUERY = 8'h98;
  localparam logic [7:0] FWB_C_LOCK = 8'h60;
  localparam logic [7:0] FWB_C_PROT = 8'hc0;
  localparam logic [7:0] FWB_C_RD_ARRAY = 8'hff;
  localparam logic [7:0] FWB_C_BUF_PROG = 8'he8;
  localparam logic [7:0] FWB_C_CONFIRM = 8'hd0;
  localparam logic [7:0] FWB_C_ERASE = 8'h20;
  localparam logic [7:0] FWB_C_SUSPEND = 8'hb0;
  localparam logic [7:0] FWB_STS_MAX = 8'h03;  // highest legal status-pin mode

  // ---------------------------------------------------------------------------
  // status register fields
  // ---------------------------------------------------------------------------
  localparam int FWB_SR_READY = 7;
  localparam int FWB_SR_ESUSP = 6;
  localparam int FWB_SR_EERR = 5;
  localparam int FWB_SR_PERR = 4;
  localparam int FWB_SR_LOW = 0;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int FWB_CLK_NS = 8;
  localparam int FWB_PROG_NS = 1000;
  localparam int FWB_ERASE_NS = 2000;
  localparam int FWB_PROG_CYC = FWB_PROG_NS / FWB_CLK_NS;
  localparam int FWB_ERASE_CYC = FWB_ERASE_NS / FWB_CLK_NS;
  localparam int FWB_SETTLE_CYC = 2;           // host write to visible status

  typedef enum logic [3:0] {
    FWB_CMD_NONE, FWB_CMD_RD_STATUS, FWB_CMD_CLEAR, FWB_CMD_RD_CONFIG,
    FWB_CMD_STS, FWB_CMD_QUERY, FWB_CMD_LOCK, FWB_CMD_PROT, FWB_CMD_RD_ARRAY,
    FWB_CMD_BUF_PROG, FWB_CMD_CONFIRM, FWB_CMD_ERASE, FWB_CMD_SUSPEND
  } fwb_cmd_t;

  // device interpreter states, gray along array-status-count-data-confirm-prog
  typedef enum logic [3:0] {
    FWB_ST_ARRAY = 4'h0, FWB_ST_STATUS = 4'h1, FWB_ST_COUNT = 4'h3,
    FWB_ST_DATA = 4'h2, FWB_ST_CONFIRM = 4'h6, FWB_ST_PROG = 4'h7,
    FWB_ST_ERS_SETUP = 4'h5, FWB_ST_ERS_BUSY = 4'h4, FWB_ST_CONFIG = 4'hc,
    FWB_ST_QUERY = 4'hd, FWB_ST_LOCK = 4'hf, FWB_ST_STS = 4'he
  } fwb_state_t;

  typedef enum logic [2:0] {
    FWB_OP_BUF_PROG, FWB_OP_ERASE, FWB_OP_SUSPEND, FWB_OP_RESUME,
    FWB_OP_CLEAR, FWB_OP_RD_ARRAY
  } fwb_op_t;

  typedef enum logic [2:0] {
    FWB_H_IDLE = 3'h0, FWB_H_SETUP = 3'h1, FWB_H_CHECK = 3'h3, FWB_H_COUNT = 3'h2,
    FWB_H_DATA = 3'h6, FWB_H_CONFIRM = 3'h7, FWB_H_POLL = 3'h5, FWB_H_SINGLE = 3'h4
  } fwb_hstate_t;

endpackage : fwb_pkg

/* File: shared/fwb_if.sv */
// bus cycles between the host controller and the flash command interpreter
`timescale 1ns/1ps
interface fwb_if;
  import fwb_pkg::*;
  logic wr;
  logic [FWB_ADDR_W-1:0] addr;
  logic [FWB_DATA_W-1:0] wdata;
  logic [FWB_DATA_W-1:0] rd_data;
  logic [7:0] status;

  modport dev (input wr, input addr, input wdata, output rd_data, output status);
  modport host (output wr, output addr, output wdata, input rd_data, input status);
endinterface : fwb_if

/* File: hw/fwb_cmd_decode.sv */
// classifies the low byte of a write cycle into a command kind
`timescale 1ns/1ps
module fwb_cmd_decode
  import fwb_pkg::*;
(
  input wire logic [7:0] code,
  output fwb_cmd_t kind,
  output logic ordinary
);

  // ---------------------------------------------------------------------------
  // code lookup
  // ---------------------------------------------------------------------------
  always_comb begin
    case (code)
      FWB_C_RD_STATUS: kind = FWB_CMD_RD_STATUS;
      FWB_C_CLEAR: kind = FWB_CMD_CLEAR;
      FWB_C_RD_CONFIG: kind = FWB_CMD_RD_CONFIG;
      FWB_C_STS: kind = FWB_CMD_STS;
      FWB_C_QUERY: kind = FWB_CMD_QUERY;
      FWB_C_LOCK: kind = FWB_CMD_LOCK;
      FWB_C_PROT: kind = FWB_CMD_PROT;
      FWB_C_RD_ARRAY: kind = FWB_CMD_RD_ARRAY;
      FWB_C_BUF_PROG: kind = FWB_CMD_BUF_PROG;
      FWB_C_CONFIRM: kind = FWB_CMD_CONFIRM;
      FWB_C_ERASE: kind = FWB_CMD_ERASE;
      FWB_C_SUSPEND: kind = FWB_CMD_SUSPEND;
      default: kind = FWB_CMD_NONE;
    endcase
  end

  // status read, clear, configuration, lock and protection codes form one class
  assign ordinary = (kind inside {FWB_CMD_RD_STATUS, FWB_CMD_CLEAR, FWB_CMD_RD_CONFIG,
                                  FWB_CMD_STS, FWB_CMD_QUERY, FWB_CMD_LOCK,
                                  FWB_CMD_PROT});

endmodule : fwb_cmd_decode

/* File: hw/fwb_device.sv */
// flash command interpreter: buffered program, erase and erase suspend
// Summary of operation
// - host repeats buffer setup until ready bit
// - setup during suspend keeps erase suspended
// - host writes word count minus one
// - only five low count bits kept
// - after count, writes are data loads
// - data loads accepted until count reached
// - host follows full buffer with confirm
// - host aborts by writing another block
// - data load to other block botches
// - ordinary code at confirm/erase setup botches
// - suspended confirm botch keeps suspension
// - buffer program rejected until status cleared
`timescale 1ns/1ps
module fwb_device
  import fwb_pkg::*;
#(
  parameter int ADDR_W = FWB_ADDR_W,
  parameter int PROG_CYC = FWB_PROG_CYC,
  parameter int ERASE_CYC = FWB_ERASE_CYC,
  parameter logic [15:0] ID_CODE = FWB_ID_CODE  // arbitrary value
)
(
  input wire logic clk_sys,
  input wire logic rst,
  fwb_if.dev bus,
  output logic busy,
  output logic erase_suspended,
  output logic [1:0] sts_mode
);

  // ---------------------------------------------------------------------------
  // state and decode
  // ---------------------------------------------------------------------------
  fwb_state_t state, next_state;
  logic susp, next_susp;
  logic [1:0] err, next_err;                 // {erase error, program error}
  logic [FWB_CNT_W-1:0] cnt, next_cnt;
  logic [FWB_CNT_W-1:0] idx, next_idx;
  logic [ADDR_W-FWB_BLOCK_LSB-1:0] blk, next_blk;
  logic [1:0] sts_r, next_sts;
  logic [15:0] tmr, next_tmr;
  logic [15:0] rd_r, next_rd;
  logic buf_we;
  logic [15:0] buf_mem [FWB_BUF_DEPTH];
  fwb_cmd_t cmd;

  // at confirm and erase setup every code but confirm botches, so the ordinary class is not needed
  fwb_cmd_decode u_dec (
    .code(bus.wdata[7:0]),
    .kind(cmd),
    .ordinary()
  );

  wire [ADDR_W-FWB_BLOCK_LSB-1:0] wr_blk = bus.addr[ADDR_W-1:FWB_BLOCK_LSB];
  wire same_blk = (wr_blk == blk);
  wire is_busy = (state == FWB_ST_PROG) || (state == FWB_ST_ERS_BUSY);
  wire tmr_done = (tmr == 16'h0000);
  wire status_mode = !(state inside {FWB_ST_ARRAY, FWB_ST_CONFIG, FWB_ST_QUERY});
  wire [7:0] status_word = {~is_busy, susp, err[1], err[0], 4'h0};

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_susp = susp;
    next_err = err;
    next_cnt = cnt;
    next_idx = idx;
    next_blk = blk;
    next_sts = sts_r;
    next_tmr = tmr;
    buf_we = 1'b0;
    case (state)
      FWB_ST_ARRAY, FWB_ST_STATUS, FWB_ST_CONFIG, FWB_ST_QUERY: begin
        if (bus.wr) begin
          // the suspension flag is left alone except by confirm, which resumes the suspended erase
          case (cmd)
            FWB_CMD_RD_STATUS: next_state = FWB_ST_STATUS;
            FWB_CMD_CLEAR: begin
              next_err = 2'b00;
              next_state = FWB_ST_ARRAY;
            end
            FWB_CMD_RD_CONFIG: next_state = FWB_ST_CONFIG;
            FWB_CMD_STS: next_state = FWB_ST_STS;
            FWB_CMD_QUERY: next_state = FWB_ST_QUERY;
            FWB_CMD_LOCK: next_state = FWB_ST_LOCK;
            // protection programming is not offered while erase is suspended
            FWB_CMD_PROT: next_state = susp ? FWB_ST_ARRAY : FWB_ST_LOCK;
            FWB_CMD_BUF_PROG: begin
              // a leftover sequence error refuses the setup; status shows it
              if (err != 2'b00) begin
                next_state = FWB_ST_STATUS;
              end else begin
                next_state = FWB_ST_COUNT;
              end
            end
            // erase cannot nest inside a suspended erase
            FWB_CMD_ERASE: next_state = susp ? FWB_ST_ARRAY : FWB_ST_ERS_SETUP;
            FWB_CMD_CONFIRM: begin
              if (susp) begin
                next_susp = 1'b0;
                next_state = FWB_ST_ERS_BUSY;
              end else begin
                next_state = FWB_ST_ARRAY;
              end
            end
            default: next_state = FWB_ST_ARRAY;
          endcase
        end
      end
      FWB_ST_COUNT: begin
        if (bus.wr) begin
          next_cnt = bus.wdata[FWB_CNT_W-1:0];
          next_idx = '0;
          next_blk = wr_blk;
          next_state = FWB_ST_DATA;
        end
      end
      FWB_ST_DATA: begin
        if (bus.wr) begin
          if (!same_blk) begin
            next_err = 2'b11;
            next_state = FWB_ST_STATUS;
          end else begin
            buf_we = 1'b1;
            if (idx == cnt) begin
              next_state = FWB_ST_CONFIRM;
            end else begin
              next_idx = idx + 1'b1;
            end
          end
        end
      end
      FWB_ST_CONFIRM: begin
        if (bus.wr) begin
          if (cmd == FWB_CMD_CONFIRM) begin
            next_tmr = 16'(PROG_CYC - 1);
            next_state = FWB_ST_PROG;
          end else begin
            // susp is held, so the error stays the suspended variant
            next_err = 2'b11;
            next_state = FWB_ST_STATUS;
          end
        end
      end
      FWB_ST_ERS_SETUP: begin
        if (bus.wr) begin
          if (cmd == FWB_CMD_CONFIRM) begin
            next_tmr = 16'(ERASE_CYC - 1);
            next_state = FWB_ST_ERS_BUSY;
          end else begin
            next_err = 2'b11;
            next_state = FWB_ST_STATUS;
          end
        end
      end
      FWB_ST_PROG: begin
        // writes are ignored while programming; the host sees ready low
        if (tmr_done) begin
          next_state = FWB_ST_STATUS;
        end else begin
          next_tmr = tmr - 16'h0001;
        end
      end
      FWB_ST_ERS_BUSY: begin
        // only suspend is heard; the remaining time is kept for resume unless a confirmed buffer program reloads tmr meanwhile
        if (bus.wr && cmd == FWB_CMD_SUSPEND) begin
          next_susp = 1'b1;
          next_state = FWB_ST_STATUS;
        end else if (tmr_done) begin
          next_state = FWB_ST_STATUS;
        end else begin
          next_tmr = tmr - 16'h0001;
        end
      end
      FWB_ST_STS: begin
        if (bus.wr) begin
          if (bus.wdata[7:0] <= FWB_STS_MAX) begin
            next_sts = bus.wdata[1:0];
            next_state = FWB_ST_STATUS;
          end else begin
            next_err = 2'b11;
            next_state = FWB_ST_STATUS;
          end
        end
      end
      FWB_ST_LOCK: begin
        // the lock or protection second cycle completes at once
        if (bus.wr) begin
          next_state = FWB_ST_STATUS;
        end
      end
      default: next_state = FWB_ST_ARRAY;
    endcase
  end

  // read data: status in status modes, buffer contents stand in for the array
  always_comb begin
    if (status_mode) begin
      next_rd = {8'h00, status_word};
    end else if (state == FWB_ST_ARRAY) begin
      next_rd = buf_mem[bus.addr[FWB_CNT_W-1:0]];
    end else if (state == FWB_ST_CONFIG) begin
      next_rd = ID_CODE;
    end else begin
      next_rd = 16'h0000;                 // query structure is not held here
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= FWB_ST_ARRAY;
      susp <= 1'b0;
      err <= 2'b00;
      cnt <= '0;
      idx <= '0;
      blk <= '0;
      sts_r <= 2'b00;
      tmr <= 16'h0000;
      rd_r <= 16'h0000;
    end else begin
      state <= next_state;
      susp <= next_susp;
      err <= next_err;
      cnt <= next_cnt;
      idx <= next_idx;
      blk <= next_blk;
      sts_r <= next_sts;
      tmr <= next_tmr;
      rd_r <= next_rd;
    end
  end

  // write buffer, one flop word per entry
  genvar gi;
  generate
    for (gi = 0; gi < FWB_BUF_DEPTH; gi++) begin : g_buf
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          buf_mem[gi] <= 16'h0000;
        end else if (buf_we && idx == FWB_CNT_W'(gi)) begin
          buf_mem[gi] <= bus.wdata;
        end
      end
    end
  endgenerate

  assign bus.rd_data = rd_r;
  assign bus.status = status_word;
  assign busy = is_busy;
  assign erase_suspended = susp;
  assign sts_mode = sts_r;

endmodule : fwb_device

/* File: hw/fwb_host.sv */
// host controller end: turns user operations into flash command cycles
`timescale 1ns/1ps
module fwb_host
  import fwb_pkg::*;
#(
  parameter int ADDR_W = FWB_ADDR_W
)
(
  input wire logic clk_sys,
  input wire logic rst,
  fwb_if.host bus,
  input wire logic op_start,
  input wire fwb_op_t op_code,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic [5:0] op_words,
  input wire logic [15:0] data_in,
  output logic data_take,
  input wire logic op_abort,
  output logic op_busy,
  output logic op_done,
  output logic [7:0] op_status
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  fwb_hstate_t hs, next_hs;
  logic wr_r, next_wr;
  logic [ADDR_W-1:0] addr_r, next_addr;
  logic [15:0] wdata_r, next_wdata;
  logic [5:0] left, next_left;
  logic [1:0] settle, next_settle;
  logic [7:0] stat_r, next_stat;
  logic done_r, next_done;
  logic [7:0] single_code;

  wire status_ok = (settle == 2'b00);
  wire ready = bus.status[FWB_SR_READY];
  wire seq_err = bus.status[FWB_SR_EERR] || bus.status[FWB_SR_PERR];
  // flip from the latched address so a moving op_addr cannot fake a block change
  wire [ADDR_W-1:0] other_blk = addr_r ^ (ADDR_W'(1) << FWB_BLOCK_LSB);

  // single-cycle operations map straight onto a command code
  assign single_code = (op_code == FWB_OP_SUSPEND) ? FWB_C_SUSPEND :
                       (op_code == FWB_OP_RESUME) ? FWB_C_CONFIRM :
                       (op_code == FWB_OP_CLEAR) ? FWB_C_CLEAR :
                       (op_code == FWB_OP_ERASE) ? FWB_C_ERASE : FWB_C_RD_ARRAY;

  // ---------------------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    next_hs = hs;
    next_wr = 1'b0;
    next_addr = addr_r;
    next_wdata = wdata_r;
    next_left = left;
    next_settle = (settle == 2'b00) ? 2'b00 : settle - 2'b01;
    next_stat = stat_r;
    next_done = 1'b0;
    data_take = 1'b0;
    case (hs)
      FWB_H_IDLE: begin
        if (op_start) begin
          next_addr = op_addr;
          next_left = op_words;
          next_hs = (op_code == FWB_OP_BUF_PROG) ? FWB_H_SETUP : FWB_H_SINGLE;
        end
      end
      FWB_H_SINGLE: begin
        next_wr = 1'b1;
        next_wdata = {8'h00, single_code};
        next_settle = 2'(FWB_SETTLE_CYC);
        next_hs = (op_code == FWB_OP_ERASE) ? FWB_H_CONFIRM : FWB_H_POLL;
      end
      FWB_H_SETUP: begin
        next_wr = 1'b1;
        next_wdata = {8'h00, FWB_C_BUF_PROG};
        next_settle = 2'(FWB_SETTLE_CYC);
        next_hs = FWB_H_CHECK;
      end
      FWB_H_CHECK: begin
        // a standing sequence error refuses the setup; loading on would feed commands
        if (status_ok && seq_err) begin
          next_hs = FWB_H_POLL;
        end else if (status_ok) begin
          next_hs = ready ? FWB_H_COUNT : FWB_H_SETUP;
        end
      end
      FWB_H_COUNT: begin
        next_wr = 1'b1;
        next_wdata = {10'h000, left - 6'h01};
        next_hs = FWB_H_DATA;
      end
      FWB_H_DATA: begin
        next_wr = 1'b1;
        if (op_abort) begin
          next_addr = other_blk;
          next_settle = 2'(FWB_SETTLE_CYC);
          next_hs = FWB_H_POLL;
        end else begin
          data_take = 1'b1;
          next_wdata = data_in;
          next_left = left - 6'h01;
          if (left == 6'h01) begin
            next_hs = FWB_H_CONFIRM;
          end
        end
      end
      FWB_H_CONFIRM: begin
        next_wr = 1'b1;
        next_wdata = {8'h00, FWB_C_CONFIRM};
        next_settle = 2'(FWB_SETTLE_CYC);
        next_hs = FWB_H_POLL;
      end
      FWB_H_POLL: begin
        if (status_ok && ready) begin
          next_stat = bus.status;
          next_done = 1'b1;
          next_hs = FWB_H_IDLE;
        end
      end
      default: next_hs = FWB_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hs <= FWB_H_IDLE;
      wr_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= 16'h0000;
      left <= 6'h00;
      settle <= 2'b00;
      stat_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      hs <= next_hs;
      wr_r <= next_wr;
      addr_r <= next_addr;
      wdata_r <= next_wdata;
      left <= next_left;
      settle <= next_settle;
      stat_r <= next_stat;
      done_r <= next_done;
    end
  end

  assign bus.wr = wr_r;
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign op_busy = (hs != FWB_H_IDLE);
  assign op_done = done_r;
  assign op_status = stat_r;

endmodule : fwb_host

/* File: bench/fwb_link_assertions.sv */
// concurrent checks on the host-to-device command link
`timescale 1ns/1ps
module fwb_link_assertions
  import fwb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wr,
  input wire logic [FWB_ADDR_W-1:0] addr,
  input wire logic [FWB_DATA_W-1:0] wdata,
  input wire logic [FWB_DATA_W-1:0] rd_data,
  input wire logic [7:0] status
);
  // ---------------------------------------------------------------------------
  // sequence tracker
  // ---------------------------------------------------------------------------
  logic [1:0] phase;
  logic [4:0] left;
  logic [7:0] blk;
  logic ers_setup;
  wire [7:0] code = wdata[7:0];
  wire clean = status[7] && (status[5:4] == 2'b00);
  wire same_blk = (addr[23:16] == blk);
  wire setup_ok = wr && (phase == 2'd0) && (code == FWB_C_BUF_PROG) && clean;
  // phase 1 count, 2 data, 3 confirm; only error-free setups are followed
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase <= 2'd0;
      left <= 5'h00;
      blk <= 8'h00;
      ers_setup <= 1'b0;
    end else if (wr) begin
      ers_setup <= (phase == 2'd0) && (code == FWB_C_ERASE) && clean;
      case (phase)
        2'd0: phase <= setup_ok ? 2'd1 : 2'd0;
        2'd1: begin
          phase <= 2'd2;
          left <= wdata[4:0];
          blk <= addr[23:16];
        end
        2'd2: begin
          phase <= !same_blk ? 2'd0 : (left == 5'h00) ? 2'd3 : 2'd2;
          left <= left - 5'h01;
        end
        default: phase <= 2'd0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_confirm;
    (phase == 2'd3) && wr && (code == FWB_C_CONFIRM);
  endsequence
  sequence s_busy_then_ready;
    !status[7] ##[1:300] status[7];
  endsequence

  status_low_zero_a: assert property (status[3:0] == 4'h0)
    else $error("status low nibble not zero");
  reset_status_a: assert property ($fell(rst) |-> status == 8'h80)
    else $error("status after reset wrong");
  setup_ready_a: assert property (setup_ok |=> status[7] && status[6] == $past(status[6]))
    else $error("setup not accepted");
  count_load_a: assert property (phase == 2'd1 && wr |=> clean)
    else $error("count load refused");
  data_accept_a: assert property (phase == 2'd2 && wr && same_blk |=> clean)
    else $error("data load refused");
  block_change_a: assert property (phase == 2'd2 && wr && !same_blk |=> status[5:4] == 2'b11)
    else $error("block change did not botch");
  confirm_prog_a: assert property (s_confirm |=> s_busy_then_ready)
    else $error("confirm did not start program");
  erase_busy_a: assert property (ers_setup && wr && code == FWB_C_CONFIRM |=> s_busy_then_ready)
    else $error("erase not reported busy");
  busy_read_a: assert property (!status[7] |=> rd_data == {8'h00, $past(status)})
    else $error("busy read not status");
endmodule : fwb_link_assertions

/* File: bench/tb.sv */
// self-checking bench: host and device joined, plus a device driven directly
`timescale 1ns/1ps
module tb;
  import fwb_pkg::*;
  localparam int PROG_N = 4;
  localparam int ERASE_N = 8;
  localparam logic [23:0] BLK_A = 24'h030000;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic op_start = 1'b0;
  fwb_op_t op_code = FWB_OP_CLEAR;
  logic [23:0] op_addr = 24'h000000;
  logic [5:0] op_words = 6'h01;
  logic [15:0] data_in = 16'h0000;
  logic op_abort = 1'b0;
  logic data_take, op_busy, op_done, busy_b, susp_b;
  logic [7:0] op_status;
  logic [7:0] ord [8];
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int seed;
  int takes = 0;
  int words_sent = 33;
  logic [5:0] nw;

  fwb_if bus();
  fwb_if bus2();
  fwb_device #(.PROG_CYC(PROG_N), .ERASE_CYC(ERASE_N)) u_fwb_device (.clk_sys(clk_sys),
    .rst(rst), .bus(bus), .busy(), .erase_suspended(), .sts_mode());
  fwb_host u_fwb_host (.clk_sys(clk_sys), .rst(rst), .bus(bus), .op_start(op_start),
    .op_code(op_code), .op_addr(op_addr), .op_words(op_words), .data_in(data_in),
    .data_take(data_take), .op_abort(op_abort), .op_busy(op_busy), .op_done(op_done),
    .op_status(op_status));
  // second device faces the bench directly so that host faults can be injected
  fwb_device #(.PROG_CYC(PROG_N), .ERASE_CYC(ERASE_N)) u_fwb_device_b (.clk_sys(clk_sys),
    .rst(rst), .bus(bus2), .busy(busy_b), .erase_suspended(susp_b), .sts_mode());
  fwb_link_assertions u_fwb_link_assertions (.clk_sys(clk_sys), .rst(rst), .wr(bus.wr),
    .addr(bus.addr), .wdata(bus.wdata), .rd_data(bus.rd_data), .status(bus.status));

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) data_in <= 16'($urandom);
  // words the host pulled from data_in, one per take pulse
  always @(posedge clk_sys) if (data_take === 1'b1) takes <= takes + 1;
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] exp_sr(input logic susp, input logic err);
    return {8'h00, 1'b1, susp, err, err, 4'h0};
  endfunction : exp_sr

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic hop(input fwb_op_t c, input logic [5:0] n, input logic ab);
    int k;
    @(posedge clk_sys);
    op_start <= 1'b1;
    op_code <= c;
    op_addr <= 24'($urandom);
    op_words <= n;
    op_abort <= ab;
    @(posedge clk_sys);
    op_start <= 1'b0;
    for (k = 0; k < 3000 && op_done !== 1'b1; k++) @(posedge clk_sys);
    @(posedge clk_sys);
    op_abort <= 1'b0;
    #1;
  endtask : hop

  // one write cycle on the second link; data lines scramble once released
  task automatic w2(input logic [23:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus2.wr <= 1'b1;
    bus2.addr <= a;
    bus2.wdata <= d;
    @(posedge clk_sys);
    bus2.wr <= 1'b0;
    bus2.wdata <= ~d;
    #1;
  endtask : w2

  task automatic end_sim;
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    bus2.wr = 1'b0;
    bus2.addr = 24'h000000;
    bus2.wdata = 16'h0000;
    ord = '{FWB_C_RD_STATUS, FWB_C_CLEAR, FWB_C_RD_CONFIG, FWB_C_STS, FWB_C_QUERY,
      FWB_C_LOCK, FWB_C_PROT, FWB_C_RD_ARRAY};
    seed = $urandom(32'hff9fd459);
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    hop(FWB_OP_BUF_PROG, 6'd1, 1'b0);
    chk({7'h00, op_busy, op_status}, exp_sr(1'b0, 1'b0));
    hop(FWB_OP_BUF_PROG, 6'd32, 1'b0);
    chk({8'h00, op_status}, exp_sr(1'b0, 1'b0));
    repeat (4) begin
      nw = 6'(($urandom % 32) + 1);
      words_sent += nw;
      hop(FWB_OP_BUF_PROG, nw, 1'b0);
      chk({8'h00, op_status}, exp_sr(1'b0, 1'b0));
    end
    chk(16'(takes), 16'(words_sent));
    hop(FWB_OP_BUF_PROG, 6'd8, 1'b1);
    chk({8'h00, op_status}, exp_sr(1'b0, 1'b1));
    // with the error standing the host gives up after the refused setup
    hop(FWB_OP_BUF_PROG, 6'd4, 1'b0);
    chk({8'h00, op_status}, exp_sr(1'b0, 1'b1));
    hop(FWB_OP_CLEAR, 6'd1, 1'b0);
    chk({8'h00, op_status}, exp_sr(1'b0, 1'b0));
    hop(FWB_OP_ERASE, 6'd1, 1'b0);
    chk({8'h00, op_status}, exp_sr(1'b0, 1'b0));
    for (int i = 2; i < 6; i++) begin
      hop(fwb_op_t'(i), 6'd1, 1'b0);
      chk({15'h0000, op_status[7]}, 16'h0001);
    end
    // every ordinary code must botch both confirm and erase setup
    for (int i = 0; i < 8; i++) begin
      w2(BLK_A, {8'h00, FWB_C_CLEAR});
      w2(BLK_A, {8'h00, FWB_C_BUF_PROG});
      w2(BLK_A, 16'h0000);
      w2(BLK_A, 16'($urandom));
      w2(BLK_A, {8'h00, ord[i]});
      chk({8'h00, bus2.status}, exp_sr(1'b0, 1'b1));
      w2(BLK_A, {8'h00, FWB_C_BUF_PROG});
      chk({8'h00, bus2.status}, exp_sr(1'b0, 1'b1));
      w2(BLK_A, {8'h00, FWB_C_CLEAR});
      w2(BLK_A, {8'h00, FWB_C_ERASE});
      w2(BLK_A, {8'h00, ord[i]});
      chk({8'h00, bus2.status}, exp_sr(1'b0, 1'b1));
    end
    // count with high bits set: only two data words before the confirm
    w2(BLK_A, {8'h00, FWB_C_CLEAR});
    w2(BLK_A, {8'h00, FWB_C_BUF_PROG});
    w2(BLK_A, 16'hffe1);
    w2(BLK_A, 16'($urandom));
    w2(BLK_A, 16'($urandom));
    w2(BLK_A, {8'h00, FWB_C_CONFIRM});
    chk({8'h00, bus2.status}, 16'h0000);
    chk({15'h0000, busy_b}, 16'h0001);
    repeat (PROG_N + 4) @(posedge clk_sys);
    #1;
    chk({8'h00, bus2.status}, exp_sr(1'b0, 1'b0));
    // erase, suspend, then a botched buffer program while suspended
    w2(BLK_A, {8'h00, FWB_C_ERASE});
    w2(BLK_A, {8'h00, FWB_C_CONFIRM});
    w2(BLK_A, {8'h00, FWB_C_RD_STATUS});
    chk({8'h00, bus2.status}, 16'h0000);
    chk(bus2.rd_data, 16'h0000);
    w2(BLK_A, {8'h00, FWB_C_SUSPEND});
    chk({15'h0000, susp_b}, 16'h0001);
    w2(BLK_A, {8'h00, FWB_C_BUF_PROG});
    chk({8'h00, bus2.status}, exp_sr(1'b1, 1'b0));
    w2(BLK_A, 16'h0000);
    w2(BLK_A, 16'($urandom));
    w2(BLK_A, {8'h00, FWB_C_RD_STATUS});
    chk({8'h00, bus2.status}, exp_sr(1'b1, 1'b1));
    w2(BLK_A, {8'h00, FWB_C_CLEAR});
    chk({8'h00, bus2.status}, exp_sr(1'b1, 1'b0));
    w2(BLK_A, {8'h00, FWB_C_RD_ARRAY});
    chk({8'h00, bus2.status}, exp_sr(1'b1, 1'b0));
    w2(BLK_A, {8'h00, FWB_C_RD_CONFIG});
    chk({8'h00, bus2.status}, exp_sr(1'b1, 1'b0));
    // read data is registered, so the identity word shows one edge later
    @(posedge clk_sys);
    #1;
    chk(bus2.rd_data, FWB_ID_CODE);
    w2(BLK_A, {8'h00, FWB_C_CONFIRM});
    chk({8'h00, bus2.status}, 16'h0000);
    repeat (ERASE_N + 4) @(posedge clk_sys);
    #1;
    chk({8'h00, bus2.status}, exp_sr(1'b0, 1'b0));
    end_sim();
  end
endmodule : tb
